// ==== core/pwr_mode_pkg.sv ====
// Package: constants, types and register map of the power-mode controller
package pwr_mode_pkg;

  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  localparam logic [7:0] PWRCYC_MS_RST = 8'h32;
  localparam logic [7:0] RSTHOLD_MS_RST = 8'h02;
  localparam logic [7:0] DEBOUNCE_MS_RST = 8'h05;
  localparam logic [11:0] SHORT_MS_RST = 12'h064;
  localparam logic [11:0] LONG_MS_RST = 12'hbb8;
  localparam logic [11:0] GUARD_MS_RST = 12'h3e8;

  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] TIMING_OFS = 12'h004;
  localparam logic [11:0] KEYTIME_OFS = 12'h008;
  localparam logic [11:0] INTR_CFG_OFS = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] EVENT_OFS = 12'h014;
  localparam logic [11:0] CMD_OFS = 12'h018;

  localparam int CTRL_BOOT_BIT = 0;
  localparam int CTRL_WAKE_LSB = 1;
  localparam int CMD_SUSPEND_BIT = 0;
  localparam int CMD_OFF_BIT = 1;
  localparam int CMD_CANCEL_BIT = 2;
  localparam int CMD_ACK0_BIT = 3;
  localparam int CMD_ACK1_BIT = 4;

  localparam int EV_SHORT = 0;
  localparam int EV_LONG = 1;
  localparam int EV_INTR0 = 2;
  localparam int EV_INTR1 = 3;
  localparam int EV_WAKE = 4;
  localparam int EV_W = 5;

  typedef enum logic [2:0] {
    ST_INIT_OFF = 3'b000,
    ST_INIT_RST = 3'b001,
    ST_RUN = 3'b010,
    ST_SUSPEND = 3'b011,
    ST_OFF = 3'b100,
    ST_COIN = 3'b101,
    ST_WAIT_KEY = 3'b110
  } pwr_state_t;

endpackage : pwr_mode_pkg

// ==== core/key_if.sv ====
// Interface: debounced power-key events from filter to controller
`timescale 1ns/100ps
interface key_if;
  logic tick;
  logic pressed;
  logic press_evt;
  logic short_evt;
  logic long_evt;
  logic [7:0] debounce_ms;
  logic [11:0] short_ms;
  logic [11:0] long_ms;
  modport filt (input tick, debounce_ms, short_ms, long_ms,
                output pressed, press_evt, short_evt, long_evt);
  modport ctrl (output tick, debounce_ms, short_ms, long_ms,
                input pressed, press_evt, short_evt, long_evt);
endinterface : key_if

// ==== core/key_filter.sv ====
// Power-key debounce and press-length classifier
`timescale 1ns/100ps
module key_filter
  import pwr_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic key_n_i,
  key_if.filt kif
);
  logic stable;
  logic [7:0] db_cnt;
  logic [11:0] hold_ms;
  logic long_done;
  logic next_stable;
  logic [7:0] next_db_cnt;
  logic [11:0] next_hold_ms;
  logic next_long_done;
  logic raw;

  assign raw = ~key_n_i; // RULE12
  assign kif.pressed = stable;

  always_comb begin
    next_stable = stable;
    next_db_cnt = db_cnt;
    next_hold_ms = hold_ms;
    next_long_done = long_done;
    kif.press_evt = 1'b0;
    kif.short_evt = 1'b0;
    kif.long_evt = 1'b0;
    if (raw == stable) begin
      next_db_cnt = 8'h00;
    end else if (kif.tick) begin
      if (db_cnt >= kif.debounce_ms) begin // RULE12
        next_stable = raw;
        next_db_cnt = 8'h00;
        if (raw) begin
          kif.press_evt = 1'b1;
        end else if (!long_done && hold_ms >= kif.short_ms) begin
          kif.short_evt = 1'b1; // RULE13
        end
      end else begin
        next_db_cnt = db_cnt + 8'h01;
      end
    end
    if (!stable) begin
      next_hold_ms = 12'h000;
      next_long_done = 1'b0;
    end else if (kif.tick && hold_ms != 12'hfff) begin
      next_hold_ms = hold_ms + 12'h001;
    end
    if (stable && !long_done && hold_ms >= kif.long_ms) begin
      kif.long_evt = 1'b1; // RULE14
      next_long_done = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stable <= 1'b0;
      db_cnt <= 8'h00;
      hold_ms <= 12'h000;
      long_done <= 1'b0;
    end else begin
      stable <= next_stable;
      db_cnt <= next_db_cnt;
      hold_ms <= next_hold_ms;
      long_done <= next_long_done;
    end
  end

  key_stable_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!rstn_i)
    (raw == stable) |=> (db_cnt == 8'h00))
    else $error("debounce count not cleared");
  long_once_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (!rstn_i)
    kif.long_evt |=> !kif.long_evt [*2])
    else $error("long press reported twice");
endmodule : key_filter

// ==== core/intrusion_chan.sv ====
// One intrusion channel: edge detect, sticky latch, latch status output
`timescale 1ns/100ps
module intrusion_chan
  import pwr_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic active_high_i,
  input wire logic pin_i,
  input wire logic ack_i,
  output logic event_o,
  output logic latched_o
);
  logic prev_act;
  logic latched;
  logic next_prev_act;
  logic next_latched;
  logic act;

  assign act = enable_i & (pin_i == active_high_i);
  assign latched_o = latched;

  always_comb begin
    next_prev_act = act;
    event_o = act & ~prev_act; // RULE16
    next_latched = latched;
    if (ack_i) begin
      next_latched = 1'b0;
    end
    if (event_o) begin
      next_latched = 1'b1; // RULE17
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prev_act <= 1'b0;
      latched <= 1'b0;
    end else begin
      prev_act <= next_prev_act;
      latched <= next_latched;
    end
  end

  set_wins_a: assert property ( // RULE17
    @(posedge clk_i) disable iff (!rstn_i)
    event_o |=> latched)
    else $error("intrusion event not latched");
endmodule : intrusion_chan

// ==== core/pwr_mode_ctrl.sv ====
// Power-mode controller top: state machine, APB registers, outputs
// Function
// RULE1 - Four operating modes: run, off, suspend, coin-cell.
// RULE2 - Boot-on-supply enters run as soon as supply appears.
// RULE3 - Wait-for-key boot waits for a key press before run.
// RULE4 - Run is entered after power-on or system reset.
// RULE5 - In run, processor reset released and power-on output high.
// RULE6 - Power-off event: off state, PMIC off, power-on output low.
// RULE7 - Suspend and off keep wake sources live; suspend keeps outputs.
// RULE8 - Host puts DDR in self-refresh, PMIC goes standby in suspend.
// RULE9 - Coin-cell: stay asleep, record intrusions, drive intrusion outputs.
// RULE10 - Coin-cell: supply presence returning gives a power-on event.
// RULE11 - Supply presence is digital; loss switches to coin-cell.
// RULE12 - Power key active low, debounced with configurable length.
// RULE13 - Short key press raises a suspend interrupt to host.
// RULE14 - Long key press raises a power-off interrupt to host.
// RULE15 - Guard timer forces off after power-off request unless cancelled.
// RULE16 - Two intrusion channels, configurable level, transition detect.
// RULE17 - Intrusion output at configured level while unacknowledged.
// RULE18 - Host notified of intrusions; detection works in off, coin-cell.
// RULE19 - Init holds power-on low 0-255 ms, default 50; zero skips.
// RULE20 - Enabled wake source in suspend or off returns to run.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module pwr_mode_ctrl
  import pwr_mode_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic POWER_KEY_N_I,
  input wire logic SUPPLY_PRESENCE_DETECT_I,
  input wire logic [1:0] WAKE_IRQ_I,
  input wire logic RTC_ALARM_I,
  input wire logic [1:0] INTRUSION_PIN_I,
  output logic PMIC_ENABLE_O,
  output logic CPU_RESET_N_O,
  output logic HOST_IRQ_O,
  output logic [1:0] INTRUSION_OUT_O,
  output logic [2:0] MODE_O
);
  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end

  // ==========================================================
  // Millisecond tick
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 32'(TICK_LEN - 1));
  always_comb begin
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
  end
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) tick_cnt <= 32'h0;
    else tick_cnt <= next_tick_cnt;
  end

  // ==========================================================
  // Configuration and event registers
  logic boot_on_supply;
  logic [2:0] wake_en;
  logic [7:0] pwrcyc_ms, rsthold_ms, debounce_ms;
  logic [11:0] short_ms, long_ms, guard_ms;
  logic [1:0] intr_en, intr_lvl, intr_out_en, intr_out_lvl;
  logic [EV_W-1:0] events;
  logic [31:0] cmd_wr;
  logic wr_hit, rd_hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] next_events;
  logic cancel_seen;

  assign wr_hit = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_hit = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign cmd_wr = (wr_hit && PADDR_I == CMD_OFS) ? PWDATA_I : 32'h0;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == CTRL_OFS) || (a == TIMING_OFS) || (a == KEYTIME_OFS)
      || (a == INTR_CFG_OFS) || (a == STATUS_OFS) || (a == EVENT_OFS)
      || (a == CMD_OFS);
  endfunction : mapped

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      boot_on_supply <= 1'b1;
      wake_en <= 3'h7;
      pwrcyc_ms <= PWRCYC_MS_RST;
      rsthold_ms <= RSTHOLD_MS_RST;
      debounce_ms <= DEBOUNCE_MS_RST;
      short_ms <= SHORT_MS_RST;
      long_ms <= LONG_MS_RST;
      guard_ms <= GUARD_MS_RST;
      intr_en <= 2'b00;
      intr_lvl <= 2'b11;
      intr_out_en <= 2'b00;
      intr_out_lvl <= 2'b11;
    end else if (wr_hit) begin
      case (PADDR_I)
        CTRL_OFS: begin
          boot_on_supply <= PWDATA_I[CTRL_BOOT_BIT]; // RULE2
          wake_en <= PWDATA_I[CTRL_WAKE_LSB +: 3];
        end
        TIMING_OFS: begin
          pwrcyc_ms <= PWDATA_I[7:0]; // RULE19
          rsthold_ms <= PWDATA_I[15:8];
          debounce_ms <= PWDATA_I[23:16]; // RULE12
        end
        KEYTIME_OFS: begin
          short_ms <= PWDATA_I[11:0];
          long_ms <= PWDATA_I[23:12];
        end
        INTR_CFG_OFS: begin
          guard_ms <= PWDATA_I[27:16];
          intr_en <= PWDATA_I[1:0];
          intr_lvl <= PWDATA_I[3:2];
          intr_out_en <= PWDATA_I[5:4];
          intr_out_lvl <= PWDATA_I[7:6];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Sub-blocks
  key_if kif();
  logic [1:0] intr_evt, intr_latched;
  assign kif.tick = tick;
  assign kif.debounce_ms = debounce_ms;
  assign kif.short_ms = short_ms;
  assign kif.long_ms = long_ms;

  key_filter u_key (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .key_n_i(POWER_KEY_N_I),
    .kif(kif)
  );

  intrusion_chan u_intr0 ( // RULE9
    .clk_i(MCLK_I), .rstn_i(RSTN_I), .enable_i(intr_en[0]),
    .active_high_i(intr_lvl[0]), .pin_i(INTRUSION_PIN_I[0]),
    .ack_i(cmd_wr[CMD_ACK0_BIT]), .event_o(intr_evt[0]),
    .latched_o(intr_latched[0])
  );
  intrusion_chan u_intr1 (
    .clk_i(MCLK_I), .rstn_i(RSTN_I), .enable_i(intr_en[1]),
    .active_high_i(intr_lvl[1]), .pin_i(INTRUSION_PIN_I[1]),
    .ack_i(cmd_wr[CMD_ACK1_BIT]), .event_o(intr_evt[1]),
    .latched_o(intr_latched[1])
  );

  // ==========================================================
  // Mode state machine
  pwr_state_t state, next_state;
  logic [11:0] tmr, next_tmr;
  logic guard_run, next_guard_run;
  logic wake;
  // Wake sources only count while asleep, so run logs no wake event
  assign wake = (state == ST_SUSPEND || state == ST_OFF) // RULE7
    && ((wake_en[0] & kif.press_evt) | (wake_en[1] & |WAKE_IRQ_I)
    | (wake_en[2] & RTC_ALARM_I));
  assign cancel_seen = cmd_wr[CMD_CANCEL_BIT];

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_guard_run = guard_run;
    case (state)
      ST_INIT_OFF: begin
        if (tmr >= {4'h0, pwrcyc_ms}) begin // RULE19
          next_state = ST_INIT_RST;
          next_tmr = 12'h000;
        end else if (tick) begin
          next_tmr = tmr + 12'h001;
        end
      end
      ST_INIT_RST: begin
        if (tmr >= {4'h0, rsthold_ms}) begin
          next_state = ST_RUN; // RULE4
        end else if (tick) begin
          next_tmr = tmr + 12'h001;
        end
      end
      ST_RUN: begin
        if (kif.long_evt) begin
          next_guard_run = 1'b1; // RULE15
          next_tmr = 12'h000;
        end else if (guard_run && tick) begin
          next_tmr = tmr + 12'h001;
        end
        if (cancel_seen) next_guard_run = 1'b0; // RULE15
        if (cmd_wr[CMD_OFF_BIT] ||
            (guard_run && !cancel_seen && tmr >= guard_ms)) begin
          next_state = ST_OFF; // RULE6
          next_guard_run = 1'b0;
        end else if (cmd_wr[CMD_SUSPEND_BIT]) begin
          next_state = ST_SUSPEND; // RULE8
          next_guard_run = 1'b0;
        end
      end
      ST_SUSPEND, ST_OFF: begin
        if (wake) begin // RULE20
          next_state = ST_INIT_RST;
          next_tmr = 12'h000;
        end
      end
      ST_WAIT_KEY: begin
        if (kif.press_evt) begin // RULE3
          next_state = ST_INIT_OFF;
          next_tmr = 12'h000;
        end
      end
      ST_COIN: begin
        if (SUPPLY_PRESENCE_DETECT_I) begin // RULE10
          next_state = boot_on_supply ? ST_INIT_OFF : ST_WAIT_KEY;
          next_tmr = 12'h000;
        end
      end
      default: next_state = ST_COIN;
    endcase
    if (!SUPPLY_PRESENCE_DETECT_I) begin
      next_state = ST_COIN; // RULE11
      next_guard_run = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      state <= ST_COIN; // RULE1
      tmr <= 12'h000;
      guard_run <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      guard_run <= next_guard_run;
    end
  end

  // ==========================================================
  // Events, outputs and bus answer
  assign ev_set = {wake, intr_evt[1], intr_evt[0], kif.long_evt,
    kif.short_evt};
  always_comb begin
    next_events = events;
    if (wr_hit && PADDR_I == EVENT_OFS) begin
      next_events = events & ~PWDATA_I[EV_W-1:0];
    end
    next_events = next_events | ev_set; // RULE18
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      events <= '0;
      PMIC_ENABLE_O <= 1'b0;
      CPU_RESET_N_O <= 1'b0;
      HOST_IRQ_O <= 1'b0;
      INTRUSION_OUT_O <= 2'b00;
      MODE_O <= ST_COIN;
      PRDATA_O <= 32'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      events <= next_events; // RULE13
      PMIC_ENABLE_O <= (next_state == ST_RUN) || (next_state == ST_INIT_RST)
        || (next_state == ST_SUSPEND); // RULE5
      CPU_RESET_N_O <= (next_state == ST_RUN) || (next_state == ST_SUSPEND);
      HOST_IRQ_O <= |next_events; // RULE14
      INTRUSION_OUT_O <= (intr_out_en & intr_out_lvl & intr_latched)
        | (intr_out_en & ~intr_out_lvl & ~intr_latched); // RULE17
      MODE_O <= next_state;
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped(PADDR_I);
      PRDATA_O <= 32'h0;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        case (PADDR_I)
          CTRL_OFS: PRDATA_O <= {28'h0, wake_en, boot_on_supply};
          TIMING_OFS: PRDATA_O <= {8'h0, debounce_ms, rsthold_ms, pwrcyc_ms};
          KEYTIME_OFS: PRDATA_O <= {8'h0, long_ms, short_ms};
          INTR_CFG_OFS: PRDATA_O <= {4'h0, guard_ms, 8'h0, intr_out_lvl,
            intr_out_en, intr_lvl, intr_en};
          STATUS_OFS: PRDATA_O <= {24'h0, intr_latched, guard_run,
            kif.pressed, 1'b0, state};
          EVENT_OFS: PRDATA_O <= {27'h0, events};
          default: PRDATA_O <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  sequence long_press_s;
    state == ST_RUN && kif.long_evt && !cmd_wr[CMD_OFF_BIT]
      && !cmd_wr[CMD_SUSPEND_BIT] && !cancel_seen
      && SUPPLY_PRESENCE_DETECT_I;
  endsequence
  guard_arm_a: assert property ( // RULE15
    @(posedge MCLK_I) disable iff (!RSTN_I)
    long_press_s ##1 SUPPLY_PRESENCE_DETECT_I |-> guard_run)
    else $error("guard timer not armed");
  supply_loss_a: assert property ( // RULE11
    @(posedge MCLK_I) disable iff (!RSTN_I)
    !SUPPLY_PRESENCE_DETECT_I |=> state == ST_COIN)
    else $error("no coin-cell on supply loss");
  run_pins_a: assert property ( // RULE5
    @(posedge MCLK_I) disable iff (!RSTN_I)
    state == ST_RUN |-> PMIC_ENABLE_O && CPU_RESET_N_O)
    else $error("run state pins wrong");
  off_pin_a: assert property ( // RULE6
    @(posedge MCLK_I) disable iff (!RSTN_I)
    state == ST_OFF |-> !PMIC_ENABLE_O)
    else $error("pmic enabled while off");
  coin_wake_a: assert property ( // RULE2
    @(posedge MCLK_I) disable iff (!RSTN_I)
    state == ST_COIN && SUPPLY_PRESENCE_DETECT_I && boot_on_supply
    |=> state == ST_INIT_OFF)
    else $error("boot on supply not taken");
  sleep_wake_a: assert property ( // RULE20
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (state == ST_OFF || state == ST_SUSPEND) && wake &&
    SUPPLY_PRESENCE_DETECT_I |=> state == ST_INIT_RST)
    else $error("wake source ignored");
  wait_key_a: assert property ( // RULE3
    @(posedge MCLK_I) disable iff (!RSTN_I)
    state == ST_WAIT_KEY && !kif.press_evt
    |=> state == ST_WAIT_KEY || state == ST_COIN)
    else $error("left key wait without press");
  intr_irq_a: assert property ( // RULE18
    @(posedge MCLK_I) disable iff (!RSTN_I)
    |intr_evt |=> HOST_IRQ_O && (events[EV_INTR1:EV_INTR0] != 2'b00))
    else $error("intrusion not reported");
endmodule : pwr_mode_ctrl

// ==== tb/host_pmic_model.sv ====
// Behavioural model of the host processor and PMIC beside the block
`timescale 1ns/100ps
module host_pmic_model
  import pwr_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic pmic_enable_i,
  input wire logic cpu_reset_n_i,
  input wire logic [2:0] mode_i,
  output logic rails_on_o,
  output logic always_on_rail_o,
  output logic ddr_self_refresh_o,
  output logic cpu_running_o
);
  assign always_on_rail_o = 1'b1;
  always_ff @(posedge clk_i) begin
    rails_on_o <= pmic_enable_i;
    cpu_running_o <= pmic_enable_i & cpu_reset_n_i;
    ddr_self_refresh_o <= (mode_i == ST_SUSPEND);
  end
endmodule : host_pmic_model

// ==== tb/testbench.sv ====
// Testbench: mode sequencing, power key, intrusion and register checks
`timescale 1ns/100ps
module testbench;
  import pwr_mode_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic key_n = 1'b1;
  logic supply = 1'b0;
  logic [1:0] wake = 2'b00;
  logic rtc = 1'b0;
  logic [1:0] pins = 2'b00;
  logic [31:0] prdata;
  logic pready, pslverr, pmic_en, cpu_rst_n, irq;
  logic [1:0] intr_out;
  logic [2:0] mode;
  logic rails_on, self_refresh, cpu_run;
  logic [31:0] rdata;
  logic err;
  int fail_count = 0;
  int checked = 0;
  int n;

  always #5 clk = ~clk;

  pwr_mode_ctrl #(.TICK_LEN(4)) uut (.MCLK_I(clk), .RSTN_I(rstn),
    .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .POWER_KEY_N_I(key_n), .SUPPLY_PRESENCE_DETECT_I(supply),
    .WAKE_IRQ_I(wake), .RTC_ALARM_I(rtc), .INTRUSION_PIN_I(pins),
    .PMIC_ENABLE_O(pmic_en), .CPU_RESET_N_O(cpu_rst_n),
    .HOST_IRQ_O(irq), .INTRUSION_OUT_O(intr_out), .MODE_O(mode));

  host_pmic_model far_side (.clk_i(clk), .pmic_enable_i(pmic_en),
    .cpu_reset_n_i(cpu_rst_n), .mode_i(mode), .rails_on_o(rails_on),
    .always_on_rail_o(), .ddr_self_refresh_o(self_refresh),
    .cpu_running_o(cpu_run));

  // ==========================================================
  // Checking and bus tasks
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
    if (pready !== 1'b1) tally_and_finish();
  endtask : apb

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp,
                    input logic exp_err);
    apb(1'b0, addr, 32'h0);
    chk("read data", exp, rdata);
    chk("pslverr", 32'(exp_err), 32'(err));
  endtask : rd

  task automatic wait_mode(input logic [2:0] m, input int lim);
    int k;
    k = 0;
    while (mode !== m && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk("mode", 32'(m), 32'(mode));
    if (mode !== m) tally_and_finish();
  endtask : wait_mode

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk("host irq", 32'h1, 32'(irq));
    if (irq !== 1'b1) tally_and_finish();
  endtask : wait_irq

  task automatic press(input int cyc);
    @(posedge clk);
    key_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    key_n <= 1'b1;
  endtask : press

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("mode", 32'h5, 32'(mode));
    chk("pmic", 32'h0, 32'(pmic_en));
    supply <= 1'b1;
    @(posedge clk);
    n = 0;
    while (pmic_en !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("power cycle", 32'h1, 32'(n >= 195 && n <= 205));
    wait_mode(ST_RUN, 100);
    chk("cpu reset", 32'h1, 32'(cpu_rst_n));
    chk("pmic", 32'h1, 32'(pmic_en));
    rd(CTRL_OFS, 32'h0000000f, 1'b0);
    rd(TIMING_OFS, 32'h00050232, 1'b0);
    rd(KEYTIME_OFS, 32'h00bb8064, 1'b0);
    rd(INTR_CFG_OFS, 32'h03e800cc, 1'b0);
    rd(STATUS_OFS, 32'h00000002, 1'b0);
    rd(12'h01c, 32'h0, 1'b1);
    apb(1'b1, TIMING_OFS, 32'h00010102);
    apb(1'b1, KEYTIME_OFS, 32'h00014003);
    apb(1'b1, INTR_CFG_OFS, 32'h000a00ff);
    repeat (2) @(posedge clk);
    chk("intrusion out", 32'h0, 32'(intr_out));
    // Glitch shorter than the filter, then a short press
    press(2);
    repeat (40) @(posedge clk);
    chk("host irq", 32'h0, 32'(irq));
    press(40);
    repeat (20) @(posedge clk);
    rd(EVENT_OFS, 32'h00000001, 1'b0);
    apb(1'b1, EVENT_OFS, 32'h1f);
    @(posedge clk);
    chk("host irq", 32'h0, 32'(irq));
    // Long press, cancelled shutdown
    key_n <= 1'b0;
    wait_irq(300);
    apb(1'b1, CMD_OFS, 32'h4);
    key_n <= 1'b1;
    rd(EVENT_OFS, 32'h00000002, 1'b0);
    apb(1'b1, EVENT_OFS, 32'h1f);
    repeat (80) @(posedge clk);
    chk("mode", 32'(ST_RUN), 32'(mode));
    // Long press, guard timer forces off
    key_n <= 1'b0;
    wait_irq(300);
    key_n <= 1'b1;
    wait_mode(ST_OFF, 100);
    repeat (2) @(posedge clk);
    chk("pmic", 32'h0, 32'(pmic_en));
    chk("rails", 32'h0, 32'(rails_on));
    chk("cpu running", 32'h0, 32'(cpu_run));
    press(40);
    wait_mode(ST_RUN, 300);
    // Suspend with an interrupt wake, then off with an alarm wake
    apb(1'b1, CMD_OFS, 32'h1);
    wait_mode(ST_SUSPEND, 10);
    repeat (2) @(posedge clk);
    chk("pmic", 32'h1, 32'(pmic_en));
    chk("self refresh", 32'h1, 32'(self_refresh));
    wake <= 2'b01;
    repeat (2) @(posedge clk);
    wake <= 2'b00;
    wait_mode(ST_RUN, 100);
    apb(1'b1, CMD_OFS, 32'h2);
    wait_mode(ST_OFF, 10);
    rtc <= 1'b1;
    repeat (2) @(posedge clk);
    rtc <= 1'b0;
    wait_mode(ST_RUN, 100);
    // Intrusion on channel zero in run, then acknowledge
    apb(1'b1, EVENT_OFS, 32'h1f);
    pins <= 2'b01;
    repeat (4) @(posedge clk);
    chk("intrusion out", 32'h1, 32'(intr_out));
    rd(EVENT_OFS, 32'h00000004, 1'b0);
    apb(1'b1, CMD_OFS, 32'h8);
    repeat (2) @(posedge clk);
    chk("intrusion out", 32'h0, 32'(intr_out));
    // Supply loss, intrusion one while on the coin cell
    supply <= 1'b0;
    wait_mode(ST_COIN, 10);
    pins <= 2'b11;
    repeat (4) @(posedge clk);
    chk("intrusion out", 32'h2, 32'(intr_out));
    supply <= 1'b1;
    wait_mode(ST_RUN, 100);
    rd(STATUS_OFS, 32'h00000082, 1'b0);
    apb(1'b1, CMD_OFS, 32'h10);
    repeat (2) @(posedge clk);
    chk("intrusion out", 32'h0, 32'(intr_out));
    // Wait-for-key boot
    apb(1'b1, CTRL_OFS, 32'h0000000e);
    supply <= 1'b0;
    wait_mode(ST_COIN, 10);
    supply <= 1'b1;
    repeat (60) @(posedge clk);
    chk("mode", 32'(ST_WAIT_KEY), 32'(mode));
    press(40);
    wait_mode(ST_RUN, 200);
    tally_and_finish();
  end
endmodule : testbench
